// ### lsrf_pkg.sv
// Shared constants and types of the line sensor readout formatter.
`default_nettype none
package lsrf_pkg;
  // Pixel and output word geometry.
  localparam int PIX_W       = 8;
  localparam int OUT_W       = 24;
  localparam int MAX_W       = 4096;
  // Window width limits; the width is kept to a multiple of 2**W_STEP_BITS.
  localparam int MIN_W       = 24;
  localparam int W_STEP_BITS = 3;
  // Frame height limits of the two-dimensional geometry.
  localparam int H_MIN       = 2;
  localparam int H_MAX       = 16384;
  // Fixed vertical start of the window.
  localparam int V_START     = 0;

  typedef enum logic {GEOM_AREA, GEOM_LINE} lsrf_geom_e;
  typedef enum logic [1:0] {LAY_MONO, LAY_RGB, LAY_BGR, LAY_RAW} lsrf_lay_e;
  typedef enum logic {ORD_FWD, ORD_BWD} lsrf_ord_e;

  // Reset values of the latched configuration.
  localparam lsrf_geom_e GEOM_RST = GEOM_LINE;
  localparam lsrf_lay_e  LAY_RST  = LAY_MONO;
  localparam lsrf_ord_e  ORD_RST  = ORD_FWD;
endpackage
`default_nettype wire

// ### lsrf_link_if.sv
// Handshake and line memory port between the sensor side and the link side.
`timescale 1ns/1ns
`default_nettype none
interface lsrf_link_if #(
  parameter int XW = 13,
  parameter int AW = 13
);
  logic                    req;
  logic                    ack;
  logic [1:0]              nl;
  logic                    fs;
  logic                    fe;
  logic [XW-1:0]           wid;
  logic [AW-1:0]           rd_addr;
  logic [lsrf_pkg::OUT_W-1:0] rd_data;

  modport core (output req, nl, fs, fe, wid, rd_data, input ack, rd_addr);
  modport tx   (input req, nl, fs, fe, wid, rd_data, output ack, rd_addr);
endinterface
`default_nettype wire

// ### lsrf_sync.sv
// Two flip-flop synchroniser for levels and toggles.
`timescale 1ns/1ns
`default_nettype none
module lsrf_sync (
  // Destination clock and reset.
  input  wire logic clk,
  input  wire logic rst,
  // Asynchronous level in, synchronised level out.
  input  wire logic d,
  output logic      q
);
  typedef struct packed {
    logic s1;
    logic s2;
  } lsrf_sync_s;

  lsrf_sync_s r, n;

  // Only the second stage is ever read outside this module.
  always_comb
  begin
    n.s1 = d;
    n.s2 = r.s1;
  end

  // State register.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      r <= '0;
    else
      r <= n;
  end

  assign q = r.s2;
endmodule // lsrf_sync
`default_nettype wire

// ### lsrf_link_tx.sv
// Link-side transmitter that streams stored lines out on the link clock.
`timescale 1ns/1ns
`default_nettype none
module lsrf_link_tx #(
  parameter int MAX_W = lsrf_pkg::MAX_W,
  parameter int XW    = 13,
  parameter int AW    = 13
) (
  // Link clock domain.
  input  wire logic               link_clk,
  input  wire logic               rst,
  // Handshake and memory port.
  lsrf_link_if.tx                 lk,
  // Link outputs.
  output logic                    cl_fval,
  output logic                    cl_lval,
  output logic                    cl_dval,
  output logic [lsrf_pkg::OUT_W-1:0] cl_data
);
  import lsrf_pkg::*;

  typedef enum logic [1:0] {T_IDLE, T_LINE, T_GAP} lsrf_tst_e;
  typedef struct packed {
    lsrf_tst_e       st;
    logic            ack;
    logic            li;
    logic [XW-1:0]   col;
    logic            fval;
    logic            lval;
    logic [OUT_W-1:0] data;
  } lsrf_tx_s;

  lsrf_tx_s r, n;
  logic     req_s;

  // The request toggle crosses in from the sensor domain.
  lsrf_sync u_req_sync (
    .clk (link_clk),
    .rst (rst),
    .d   (lk.req),
    .q   (req_s)
  );

  // The stored words are stable while the request is open, so no further crossing is needed.
  always_comb
  begin
    n = r;
    case (r.st)
      T_IDLE:
      begin
        n.lval = 1'b0;
        if (req_s != r.ack)
        begin
          n.li  = 1'b0;
          n.col = '0;
          n.st  = (lk.wid == '0) ? T_GAP : T_LINE;
          if (lk.fs)
            n.fval = 1'b1;
        end
      end
      T_LINE:
      begin
        n.lval = 1'b1;
        n.data = lk.rd_data;
        n.col  = r.col + XW'(1);
        if (r.col == lk.wid - XW'(1))
          n.st = T_GAP;
      end
      default:
      begin
        n.lval = 1'b0;
        n.col  = '0;
        if (!r.li && lk.nl == 2'd2 && lk.wid != '0)
        begin
          n.li = 1'b1;
          n.st = T_LINE;
        end
        else
        begin
          n.st  = T_IDLE;
          n.ack = req_s;
          if (lk.fe)
            n.fval = 1'b0;
        end
      end
    endcase
  end

  // State register.
  always_ff @(posedge link_clk or posedge rst)
  begin
    if (rst)
      r <= '0;
    else
      r <= n;
  end

  assign lk.rd_addr = r.li ? AW'(MAX_W) + AW'(r.col) : AW'(r.col);
  assign lk.ack     = r.ack;
  assign cl_fval    = r.fval;
  assign cl_lval    = r.lval;
  assign cl_dval    = r.lval;
  assign cl_data    = r.data;
endmodule // lsrf_link_tx
`default_nettype wire

// ### lsrf_formatter.sv
// Line sensor readout formatter: geometry, stages, layout, order and window.
//
// Function
// - Two-dimensional geometry builds multi-row frames from both sensor pixel rows.
// - Single-row geometry delivers one sensor line per acquisition.
// - Two-dimensional frame height is 2 to 16384 rows, frames hold that many.
// - Single-row stage count picks one or two accumulated stages per line in mono layout on a mono sensor; other layouts ignore it.
// - Two stages sum both rows, roughly doubling sensitivity.
// - Single-row colour data is converted to mono, RGB, BGR or raw bilinear layout; two-dimensional geometry sends plain rows.
// - Single-row mono layout on a colour sensor sends only green pixels.
// - RGB and BGR values interpolate neighbouring sensor pixels.
// - Raw bilinear layout sends native pixels uninterpolated, fewer bytes per pixel.
// - Single-row readout order picks row a (forward) or row b (backward) as the single stage in mono layout on a mono sensor.
// - Backward order in two-dimensional geometry swaps the two rows of each pair.
// - Only pixels inside the horizontal window are stored and sent.
// - Window starts at the horizontal start pixel and spans the width.
// - Width resets to maximum; host sets width before horizontal start.
// - Width is a multiple of 8 pixels.
// - Width is never below 24 pixels.
// - Single-row vertical start is fixed at zero.
`timescale 1ns/1ns
`default_nettype none
module lsrf_formatter #(
  parameter int MAX_W = lsrf_pkg::MAX_W,
  parameter int H_MAX = lsrf_pkg::H_MAX,
  parameter int XW    = $clog2(MAX_W + 1),
  parameter int HW    = $clog2(H_MAX + 1)
) (
  // Core clock, asynchronous active-high reset, and link clock.
  input  wire logic                      ref_clk,
  input  wire logic                      rst,
  input  wire logic                      link_clk,
  // Configuration from host logic.
  input  wire lsrf_pkg::lsrf_geom_e      scan_geometry_select,
  input  wire logic [HW-1:0]             frame_height,
  input  wire logic                      stage_count_two,
  input  wire lsrf_pkg::lsrf_lay_e       out_layout,
  input  wire lsrf_pkg::lsrf_ord_e       readout_order,
  input  wire logic                      colour_sensor,
  input  wire logic [XW-1:0]             window_horizontal_start,
  input  wire logic [XW-1:0]             window_width_in,
  input  wire logic                      window_width_wr,
  // Sensor pixel stream, one column per valid cycle.
  input  wire logic                      sens_line_start,
  input  wire logic                      sens_pix_valid,
  input  wire logic [lsrf_pkg::PIX_W-1:0] sens_row_a,
  input  wire logic [lsrf_pkg::PIX_W-1:0] sens_row_b,
  // Frame grabber link.
  output logic                           cl_fval,
  output logic                           cl_lval,
  output logic                           cl_dval,
  output logic [lsrf_pkg::OUT_W-1:0]     cl_data,
  // Status.
  output logic [XW-1:0]                  window_width,
  output logic [XW-1:0]                  window_vertical_start,
  output logic                           busy,
  output logic                           line_dropped
);
  import lsrf_pkg::*;

  // The line memory holds two rows of the widest window, one per half, so the
  // address carries one bit more than a column address of a single row.
  localparam int AW = $clog2(2 * MAX_W);

  // Idle waits for a line start, capture takes the columns, send waits for the link.
  // All sequencer state lives in one record, so reset and register stay in one place.
  typedef enum logic [1:0] {ST_IDLE, ST_CAPT, ST_SEND} lsrf_st_e;
  typedef struct packed {
    lsrf_st_e        st;
    lsrf_geom_e      geom;
    lsrf_lay_e       lay;
    lsrf_ord_e       ord;
    logic            stg2;
    logic            colr;
    logic [HW-1:0]   height;
    logic [HW-1:0]   row;
    logic [XW-1:0]   wid;
    logic [XW-1:0]   lwid;
    logic [XW-1:0]   wstart;
    logic [XW-1:0]   x;
    logic [XW-1:0]   wcnt;
    logic [PIX_W-1:0] b1;
    logic [PIX_W-1:0] b2;
    logic [PIX_W-1:0] b3;
    logic            req;
    logic [1:0]      nl;
    logic            fs;
    logic            fe;
    logic            drop;
  } lsrf_core_s;

  lsrf_core_s       r, n;
  // Line store; it is written on the core clock during capture and read from the
  // link side only while the request is open, so the two ends never overlap.
  logic [OUT_W-1:0] mem [0:2*MAX_W-1];
  // Write ports of the store, one per half, driven by the sequencer.
  logic             we0;
  logic             we1;
  logic [AW-1:0]    wa0;
  logic [AW-1:0]    wa1;
  logic [OUT_W-1:0] wd0;
  logic [OUT_W-1:0] wd1;
  // Returned handshake toggle, and the combinational helpers of the current column.
  logic             ack_s;
  logic [XW:0]      win_end;
  logic             in_win;
  logic [PIX_W-1:0] stg;
  logic [PIX_W-1:0] oth;
  logic [PIX_W-1:0] red;
  logic [PIX_W-1:0] blu;
  logic [HW-1:0]    rem;
  logic [HW-1:0]    h_eff;

  lsrf_link_if #(.XW(XW), .AW(AW)) lk ();

  // Saturating sum so that a doubled stage clips instead of wrapping.
  function automatic logic [PIX_W-1:0] sat_add(input logic [PIX_W-1:0] a,
                                               input logic [PIX_W-1:0] b);
    logic [PIX_W:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[PIX_W] ? {PIX_W{1'b1}} : s[PIX_W-1:0];
  endfunction

  // Mean of two pixels, rounding down.
  function automatic logic [PIX_W-1:0] avg2(input logic [PIX_W-1:0] a,
                                            input logic [PIX_W-1:0] b);
    logic [PIX_W:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[PIX_W:1];
  endfunction

  // Widths are forced onto the 8-pixel grid and into the legal range.
  function automatic logic [XW-1:0] clamp_w(input logic [XW-1:0] w);
    logic [XW-1:0] m;
    m = w & ~XW'((1 << W_STEP_BITS) - 1);
    if (m < XW'(MIN_W))
      m = XW'(MIN_W);
    else if (m > XW'(MAX_W))
      m = XW'(MAX_W);
    return m;
  endfunction

  // The link hands back the request toggle once it has sent the stored lines.
  // A toggle, not a pulse, crosses so that no event is lost between the two clocks.
  lsrf_sync u_ack_sync (
    .clk (ref_clk),
    .rst (rst),
    .d   (lk.ack),
    .q   (ack_s)
  );

  // Link-side transmitter on its own clock.
  lsrf_link_tx #(.MAX_W(MAX_W), .XW(XW), .AW(AW)) u_tx (
    .link_clk (link_clk),
    .rst      (rst),
    .lk       (lk),
    .cl_fval  (cl_fval),
    .cl_lval  (cl_lval),
    .cl_dval  (cl_dval),
    .cl_data  (cl_data)
  );

  // Window test against the latched start and width; a window past the array end is clipped.
  always_comb
  begin
    win_end = {1'b0, r.wstart} + {1'b0, r.lwid};
    in_win  = (r.x >= r.wstart) && ({1'b0, r.x} < win_end);
  end

  // Stage combination and colour interpolation for the current column.
  always_comb
  begin
    if (r.stg2)
      stg = sat_add(sens_row_a, sens_row_b);
    else if (r.ord == ORD_BWD)
      stg = sens_row_b;
    else
      stg = sens_row_a;
    // The missing colour is the mean of the two nearest same-colour pixels to the left.
    oth = avg2(r.b1, r.b3);
    red = r.x[0] ? oth : sens_row_b;
    blu = r.x[0] ? sens_row_b : oth;
  end

  // Rows left in the frame and the effective height.
  // A height below the legal minimum is read as the minimum rather than refused.
  always_comb
  begin
    h_eff = (r.height < HW'(H_MIN)) ? HW'(H_MIN) : r.height;
    rem   = h_eff - r.row;
  end

  // Main sequencer: latch settings, capture one line, hand it over, wait for release.
  always_comb
  begin
    n      = r;
    n.drop = 1'b0;
    we0    = 1'b0;
    we1    = 1'b0;
    wa0    = '0;
    wa1    = '0;
    wd0    = '0;
    wd1    = '0;
    if (window_width_wr)
      n.wid = clamp_w(window_width_in);
    case (r.st)
      ST_IDLE:
      begin
        // A line start is taken only here; the colour history starts from zero.
        if (sens_line_start)
        begin
          n.st   = ST_CAPT;
          n.x    = '0;
          n.wcnt = '0;
          n.b1   = '0;
          n.b2   = '0;
          n.b3   = '0;
          // Settings move only between frames, never inside one.
          if (r.row == '0)
          begin
            n.geom   = scan_geometry_select;
            n.height = frame_height;
            n.stg2   = stage_count_two && (scan_geometry_select == GEOM_LINE);
            n.lay    = out_layout;
            n.ord    = readout_order;
            n.colr   = colour_sensor;
            n.lwid   = r.wid;
            n.wstart = window_horizontal_start;
          end
        end
      end
      ST_CAPT:
      begin
        if (sens_pix_valid)
        begin
          if (in_win)
          begin
            we0 = 1'b1;
            wa0 = AW'(r.wcnt);
            if (r.geom == GEOM_AREA)
            begin
              // Two sensor rows make two image rows; backward swaps them.
              // Limitation: only each pair is flipped; a flip of the whole frame would
              // need a store of every row, which this block does not carry.
              we1 = 1'b1;
              wa1 = AW'(MAX_W) + AW'(r.wcnt);
              wd0 = OUT_W'((r.ord == ORD_BWD) ? sens_row_b : sens_row_a);
              wd1 = OUT_W'((r.ord == ORD_BWD) ? sens_row_a : sens_row_b);
            end
            else
            begin
              case (r.lay)
                LAY_MONO: wd0 = OUT_W'(r.colr ? sens_row_a : stg);
                LAY_RGB:  wd0 = {red, sens_row_a, blu};
                LAY_BGR:  wd0 = {blu, sens_row_a, red};
                default:  wd0 = OUT_W'({sens_row_b, sens_row_a});
              endcase
            end
            n.wcnt = r.wcnt + XW'(1);
          end
          // Column count and colour history run over the whole array, so that the
          // interpolation at the window edge still sees its left neighbours.
          n.b3 = r.b2;
          n.b2 = r.b1;
          n.b1 = sens_row_b;
          n.x  = r.x + XW'(1);
          // The last column closes the line: the request toggles and the rows are booked.
          if (r.x == XW'(MAX_W - 1))
          begin
            n.st  = ST_SEND;
            n.req = ~r.req;
            n.fs  = (r.row == '0);
            if (r.geom == GEOM_LINE)
            begin
              n.nl  = 2'd1;
              n.fe  = 1'b1;
              n.row = '0;
            end
            else
            begin
              // A pair goes out unless one row is left; the frame ends when two rows or fewer are left.
              n.nl  = (rem >= HW'(2)) ? 2'd2 : 2'd1;
              n.fe  = (rem <= HW'(2));
              n.row = (rem <= HW'(2)) ? '0 : r.row + HW'(2);
            end
          end
        end
      end
      default:
      begin
        // A line that starts while the previous one is still on the link is lost.
        if (sens_line_start)
          n.drop = 1'b1;
        // The toggle returns after the last row has left; only then may a new line begin.
        if (ack_s == r.req)
          n.st = ST_IDLE;
      end
    endcase
  end

  // State register; the width starts at its maximum.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      r        <= '0;
      r.geom   <= GEOM_RST;
      r.lay    <= LAY_RST;
      r.ord    <= ORD_RST;
      r.height <= HW'(H_MIN);
      r.wid    <= XW'(MAX_W);
      r.lwid   <= XW'(MAX_W);
    end
    else
      r <= n;
  end

  // Line memory: first row in the lower half, second row of a pair in the upper half.
  always_ff @(posedge ref_clk)
  begin
    if (we0)
      mem[wa0] <= wd0;
    if (we1)
      mem[wa1] <= wd1;
  end

  // Handover to the link; these hold still from the request toggle until the ack returns.
  assign lk.req     = r.req;
  assign lk.nl      = r.nl;
  assign lk.fs      = r.fs;
  assign lk.fe      = r.fe;
  assign lk.wid     = r.wcnt;
  assign lk.rd_data = mem[lk.rd_addr];

  // Status outputs.
  assign window_width          = r.wid;
  assign window_vertical_start = XW'(V_START);
  // Busy covers capture and the wait for the link, so a lost line start can be foreseen.
  assign busy                  = (r.st != ST_IDLE);
  assign line_dropped          = r.drop;
endmodule // lsrf_formatter
`default_nettype wire

// ### lsrf_formatter_chk.sv
// Concurrent checks on the ports of the line sensor readout formatter.
`timescale 1ns/1ns
`default_nettype none
module lsrf_formatter_chk #(
  parameter int MAX_W = lsrf_pkg::MAX_W,
  parameter int XW    = 13
) (
  // Clocks and reset.
  input wire logic                       ref_clk,
  input wire logic                       rst,
  input wire logic                       link_clk,
  // Configuration and sensor control.
  input wire lsrf_pkg::lsrf_geom_e       scan_geometry_select,
  input wire lsrf_pkg::lsrf_lay_e        out_layout,
  input wire logic [XW-1:0]              window_horizontal_start,
  input wire logic [XW-1:0]              window_width_in,
  input wire logic                       window_width_wr,
  input wire logic                       sens_line_start,
  // Outputs under watch.
  input wire logic                       cl_fval,
  input wire logic                       cl_lval,
  input wire logic                       cl_dval,
  input wire logic [lsrf_pkg::OUT_W-1:0] cl_data,
  input wire logic [XW-1:0]              window_width,
  input wire logic [XW-1:0]              window_vertical_start,
  input wire logic                       busy,
  input wire logic                       line_dropped
);
  import lsrf_pkg::*;
  logic [XW-1:0] wexp;
  logic [XW-1:0] rexp;
  logic [XW:0]   span;
  logic [XW-1:0] run_r;
  logic [XW-1:0] run_nxt;

  // Expected loaded width and expected word count of one row.
  always_comb
  begin
    wexp = {window_width_in[XW-1:3], 3'h0};
    if (wexp < XW'(MIN_W)) wexp = XW'(MIN_W);
    if (wexp > XW'(MAX_W)) wexp = XW'(MAX_W);
    span = {1'b0, window_horizontal_start} + {1'b0, window_width};
    rexp = (span > (XW+1)'(MAX_W)) ? XW'(MAX_W) - window_horizontal_start : window_width;
    run_nxt = cl_lval ? run_r + 1'b1 : '0;
  end

  // Length of the current run of valid words; a counter avoids long repetitions.
  always_ff @(posedge link_clk or posedge rst)
    if (rst) run_r <= '0;
    else run_r <= run_nxt;

  sequence s_take;
    sens_line_start && !busy;
  endsequence
  sequence s_row_end;
    $fell(cl_lval);
  endsequence

  a_busy_hold: assert property (@(posedge ref_clk) disable iff (rst)
    s_take |=> busy [*8]) else $error("busy did not follow a taken line start");
  a_width_load: assert property (@(posedge ref_clk) disable iff (rst)
    window_width_wr |=> window_width == $past(wexp)) else $error("width load wrong");
  a_width_form: assert property (@(posedge ref_clk) disable iff (rst)
    window_width[2:0] == 3'h0 && window_width >= XW'(MIN_W)) else $error("width illegal");
  a_vstart_zero: assert property (@(posedge ref_clk) disable iff (rst)
    window_vertical_start == '0) else $error("vertical start not zero");
  a_drop_pulse: assert property (@(posedge ref_clk) disable iff (rst)
    line_dropped |-> $past(sens_line_start) && $past(busy) ##1 !line_dropped)
    else $error("line drop pulse wrong");
  a_dval_lval: assert property (@(posedge link_clk) disable iff (rst)
    cl_dval == cl_lval) else $error("data valid differs from line valid");
  a_lval_frame: assert property (@(posedge link_clk) disable iff (rst)
    cl_lval |-> cl_fval) else $error("line valid outside frame");
  a_mono_green: assert property (@(posedge link_clk) disable iff (rst)
    cl_lval && out_layout == LAY_MONO |-> cl_data[23:8] == 16'h0) else $error("mono word wide");
  a_raw_native: assert property (@(posedge link_clk) disable iff (rst)
    cl_lval && out_layout == LAY_RAW |-> cl_data[23:16] == 8'h0) else $error("raw word wide");
  a_line_frame: assert property (@(posedge link_clk) disable iff (rst)
    s_row_end and scan_geometry_select == GEOM_LINE |-> !cl_fval) else $error("frame open");
  a_row_count: assert property (@(posedge link_clk) disable iff (rst)
    s_row_end |-> run_r == rexp) else $error("row word count wrong");
endmodule // lsrf_formatter_chk

bind lsrf_formatter lsrf_formatter_chk #(.MAX_W(MAX_W), .XW(XW)) i_chk (
  .ref_clk, .rst, .link_clk, .scan_geometry_select, .out_layout, .window_horizontal_start,
  .window_width_in, .window_width_wr, .sens_line_start, .cl_fval, .cl_lval, .cl_dval,
  .cl_data, .window_width, .window_vertical_start, .busy, .line_dropped);
`default_nettype wire

// ### lsrf_fg_model.sv
// Frame grabber model that records the words and frames seen on the link.
`timescale 1ns/1ns
`default_nettype none
module lsrf_fg_model (
  // Link clock and reset.
  input wire logic                       link_clk,
  input wire logic                       rst,
  // Link signals from the camera.
  input wire logic                       cl_fval,
  input wire logic                       cl_lval,
  input wire logic                       cl_dval,
  input wire logic [lsrf_pkg::OUT_W-1:0] cl_data
);
  import lsrf_pkg::*;
  logic [OUT_W-1:0] words[$];
  int               frames = 0;
  logic             fval_r = 1'b0;

  // A grabber has no back-pressure, so every qualified word is taken as it comes.
  always @(posedge link_clk or posedge rst)
    if (rst)
    begin
      fval_r <= 1'b0;
    end
    else
    begin
      fval_r <= cl_fval;
      if (cl_fval && !fval_r) frames <= frames + 1;
      if (cl_lval && cl_dval) words.push_back(cl_data);
    end
endmodule // lsrf_fg_model
`default_nettype wire

// ### testbench.sv
// Self-checking testbench of the line sensor readout formatter.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import lsrf_pkg::*;
  localparam int XW = 13;
  logic ref_clk = 1'b0, link_clk = 1'b0, rst = 1'b1;
  lsrf_geom_e scan_geometry_select = GEOM_LINE;
  lsrf_lay_e out_layout = LAY_MONO;
  lsrf_ord_e readout_order = ORD_FWD;
  logic [14:0] frame_height = 15'h4;
  logic stage_count_two = 1'b0, colour_sensor = 1'b1, window_width_wr = 1'b0;
  logic [XW-1:0] window_horizontal_start = '0, window_width_in = '0;
  logic sens_line_start = 1'b0, sens_pix_valid = 1'b0;
  logic [7:0] sens_row_a = '0, sens_row_b = '0;
  logic cl_fval, cl_lval, cl_dval, busy, line_dropped;
  logic [OUT_W-1:0] cl_data;
  logic [XW-1:0] window_width, window_vertical_start;
  int error_cnt = 0, total_checks = 0, cyc = 0;

  lsrf_formatter i_dut (.ref_clk, .rst, .link_clk, .scan_geometry_select, .frame_height,
    .stage_count_two, .out_layout, .readout_order, .colour_sensor, .window_horizontal_start,
    .window_width_in, .window_width_wr, .sens_line_start, .sens_pix_valid, .sens_row_a,
    .sens_row_b, .cl_fval, .cl_lval, .cl_dval, .cl_data, .window_width,
    .window_vertical_start, .busy, .line_dropped);
  lsrf_fg_model i_fg (.link_clk, .rst, .cl_fval, .cl_lval, .cl_dval, .cl_data);

  // Core clock, and a link clock whose rising edges never meet those of the core clock.
  always #10 ref_clk = ~ref_clk;
  always #16 link_clk = ~link_clk;

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // A hang is cut short well beyond the expected run of about 42000 cycles.
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      error_cnt++;
      end_of_test();
    end
  end

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Words of a column: row a is x, row b is x+0x11, so means of odd neighbours are x+0x0F.
  function automatic logic [23:0] exp_w(input int x, input int m);
    logic [7:0] a, b, c;
    logic [8:0] s;
    a = x[7:0];
    b = a + 8'h11;
    c = a + 8'h0F;
    s = {1'b0, a} + {1'b0, b};
    case (m)
      0: return {16'h0, a};
      1: return {16'h0, b};
      2: return {16'h0, s[8] ? 8'hFF : s[7:0]};
      3: return {8'h0, b, a};
      4: return x[0] ? {c, a, b} : {b, a, c};
      default: return x[0] ? {b, a, c} : {c, a, b};
    endcase
  endfunction

  task automatic wait_idle;
    int n;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    while (busy !== 1'b0 && n < 20000);
    chk(24'(n < 20000), 24'h1);
  endtask

  task automatic wr_width(input logic [XW-1:0] v, input logic [XW-1:0] exp);
    @(posedge ref_clk);
    window_width_in <= v;
    window_width_wr <= 1'b1;
    @(posedge ref_clk);
    window_width_wr <= 1'b0;
    @(posedge ref_clk);
    #1;
    chk(24'(window_width), 24'(exp));
  endtask

  // Settings change only between lines, while the block is idle.
  task automatic cfg(input lsrf_geom_e g, input lsrf_lay_e l, input lsrf_ord_e o,
                     input logic t, input logic c);
    wait_idle();
    @(posedge ref_clk);
    scan_geometry_select <= g;
    out_layout <= l;
    readout_order <= o;
    stage_count_two <= t;
    colour_sensor <= c;
  endtask

  // One full sensor line; a drop request repeats the start while the block is still busy.
  task automatic send_line(input bit drop);
    wait_idle();
    @(posedge ref_clk);
    sens_line_start <= 1'b1;
    for (int x = 0; x < 4096; x++)
    begin
      @(posedge ref_clk);
      sens_line_start <= 1'b0;
      sens_pix_valid <= 1'b1;
      sens_row_a <= x[7:0];
      sens_row_b <= x[7:0] + 8'h11;
    end
    @(posedge ref_clk);
    sens_pix_valid <= 1'b0;
    sens_line_start <= drop;
    @(posedge ref_clk);
    sens_line_start <= 1'b0;
    #1;
    chk(24'(line_dropped), 24'(drop));
    wait_idle();
  endtask

  task automatic chk_row(input int m);
    logic [23:0] w;
    for (int i = 0; i < 32; i++)
    begin
      w = i_fg.words.size() > 0 ? i_fg.words.pop_front() : 'x;
      chk(w, exp_w(100 + i, m));
    end
  endtask

  initial
  begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    #1;
    chk(24'(window_width), 24'h1000);
    chk(24'(window_vertical_start), 24'h0);
    wr_width(13'h25, 13'h20);
    wr_width(13'h8, 13'h18);
    wr_width(13'h20, 13'h20);
    @(posedge ref_clk);
    window_horizontal_start <= 13'h64;
    for (int m = 0; m < 6; m++)
    begin
      cfg(GEOM_LINE, m == 3 ? LAY_RAW : m == 4 ? LAY_RGB : m == 5 ? LAY_BGR : LAY_MONO,
          m == 1 ? ORD_BWD : ORD_FWD, m == 2, m != 1 && m != 2);
      send_line(m == 0);
      chk_row(m);
      chk(24'(i_fg.words.size()), 24'h0);
      chk(24'(i_fg.frames), 24'(m + 1));
    end
    for (int o = 0; o < 2; o++)
    begin
      cfg(GEOM_AREA, LAY_MONO, o ? ORD_BWD : ORD_FWD, 1'b0, 1'b0);
      for (int k = 0; k < 2; k++)
      begin
        send_line(1'b0);
        chk_row(o);
        chk_row(1 - o);
      end
      chk(24'(i_fg.frames), 24'(7 + o));
    end
    end_of_test();
  end
endmodule // testbench
`default_nettype wire
